//--- core/sfam_core.v
// SMBus flag update, hardware address match and auto acknowledge core
`timescale 1ns/1ps
`include "sfam_defs.vh"

// Summary of operation
// - As master, a repeated START seen while start_request is low sets arbitration lost.
// - SCL found low while generating STOP or repeated START sets arbitration lost.
// - Driving a one but sensing SDA low sets arbitration lost, except on ACK bits.
// - Arbitration lost clears whenever the serial event flag is cleared.
// - Received-acknowledge flag follows the sampled ACK bit: low sets, high clears.
// - Serial event flag sets on START sent, arbitration loss, byte sent/received, address.
// - Hardware never clears the serial event flag; software does.
// - After a received byte, request software acknowledge only if auto acknowledge off.
// - Acknowledge request clears after each acknowledge bit cycle.
// - Auto acknowledge enable turns on address recognition and automatic byte acknowledge.
// - With auto acknowledge off, firmware decides every address and data acknowledge.
// - Own address and compare mask come from register bits 7 down to 1.
// - Address bits with mask one must equal own address; mask zero bits ignored.
// - With recognition on, general call enable also accepts address 0x00.
// - Own address register is read/write, general call in bit 0, resets to zero.
// - Mask register read/write, mask resets to ones, auto acknowledge bit resets zero.
module sfam_core #(
   parameter DATA_W = 8
) (
   input wire sys_clk,
   input wire reset,
   input wire [7:0] sfr_addr,
   input wire sfr_wr,
   input wire sfr_rd,
   input wire [7:0] sfr_wdata,
   output reg [7:0] sfr_rdata,
   input wire scl_in,
   input wire sda_in,
   output wire scl_out,
   output wire scl_oe_n,
   output wire sda_out,
   output wire sda_oe_n,
   input wire master_mode,
   input wire tx_active,
   input wire tx_bit_one,
   input wire gen_stop_rstart,
   input wire start_generated,
   output wire start_request,
   output wire addressed,
   output wire rx_valid,
   input wire rx_ready,
   output wire [DATA_W-1:0] rx_data
);

   // ************************************************************
   // Pin synchronisers and bus condition detection
   // ************************************************************
   reg scl_s1_q, scl_s2_q, scl_p_q;
   reg sda_s1_q, sda_s2_q, sda_p_q;
   always @(posedge sys_clk or posedge reset) begin
      if (reset) begin
         scl_s1_q <= 1'b1;
         scl_s2_q <= 1'b1;
         scl_p_q <= 1'b1;
         sda_s1_q <= 1'b1;
         sda_s2_q <= 1'b1;
         sda_p_q <= 1'b1;
      end else begin
         scl_s1_q <= scl_in;
         scl_s2_q <= scl_s1_q;
         scl_p_q <= scl_s2_q;
         sda_s1_q <= sda_in;
         sda_s2_q <= sda_s1_q;
         sda_p_q <= sda_s2_q;
      end
   end

   wire scl_rise = scl_s2_q & ~scl_p_q;
   wire scl_fall = ~scl_s2_q & scl_p_q;
   wire start_det = scl_s2_q & scl_p_q & sda_p_q & ~sda_s2_q;
   wire stop_det = scl_s2_q & scl_p_q & ~sda_p_q & sda_s2_q;

   // ************************************************************
   // Registers
   // ************************************************************
   reg [7:0] own_q;
   reg [7:0] mask_q;
   reg si_q, ackrx_q, arb_q, ackreq_q, sta_q, ackval_q;
   wire [6:0] own_field = own_q[7:1];
   wire [6:0] mask_field = mask_q[7:1];
   wire gc_en = own_q[0];
   wire auto_ack = mask_q[0];
   wire [7:0] ctrl_rd = {2'b00, ackval_q, sta_q, ackreq_q, arb_q, ackrx_q, si_q};
   wire ctrl_wr = sfr_wr && (sfr_addr == `SFAM_ADDR_CTRL);
   // Software clears the event flag by writing zero; writing one has no effect
   wire si_clr = ctrl_wr && !sfr_wdata[`SFAM_CTRL_SI];

   assign start_request = sta_q;

   // ************************************************************
   // Bit tracking on the bus
   // ************************************************************
   reg busy_q, first_q, ack_ph_q, ack_drv_q, match_q, rx_byte_q;
   reg [3:0] bit_q;
   reg [7:0] shift_q;
   wire [7:0] shift_nx = {shift_q[6:0], sda_s2_q};
   wire [6:0] in_addr = shift_nx[7:1];
   wire addr_hit = ((in_addr & mask_field) == (own_field & mask_field));
   wire gc_hit = gc_en && (in_addr == 7'h00);
   wire byte_end = scl_rise && (bit_q == `SFAM_LAST_DATA_BIT);
   wire ack_samp = scl_rise && (bit_q == `SFAM_ACK_BIT);
   wire ack_end = scl_fall && ack_ph_q;
   // Receiver of the current byte: address bytes from another master, or data we take in
   wire receiving = first_q ? !master_mode : !tx_active;

   wire arb_rst = master_mode && busy_q && start_det && !sta_q;
   wire arb_scl = gen_stop_rstart && !scl_s2_q;
   wire arb_sda = tx_active && tx_bit_one && scl_rise && !sda_s2_q &&
      (bit_q != `SFAM_ACK_BIT);
   wire arb_set = arb_rst | arb_scl | arb_sda;
   wire si_set = start_generated | arb_set | (ack_samp && tx_active) |
      (byte_end && receiving);

   always @(posedge sys_clk or posedge reset) begin
      if (reset) begin
         busy_q <= 1'b0;
         first_q <= 1'b0;
         ack_ph_q <= 1'b0;
         ack_drv_q <= 1'b0;
         match_q <= 1'b0;
         rx_byte_q <= 1'b0;
         bit_q <= 4'h0;
         shift_q <= 8'h00;
      end else if (start_det) begin
         busy_q <= 1'b1;
         first_q <= 1'b1;
         ack_ph_q <= 1'b0;
         ack_drv_q <= 1'b0;
         match_q <= 1'b0;
         bit_q <= 4'h0;
      end else if (stop_det) begin
         busy_q <= 1'b0;
         first_q <= 1'b0;
         ack_ph_q <= 1'b0;
         ack_drv_q <= 1'b0;
         match_q <= 1'b0;
         bit_q <= 4'h0;
      end else if (busy_q) begin
         if (scl_rise) begin
            // The ACK bit stays out of the shifter so a pushed byte is data only
            if (bit_q != `SFAM_ACK_BIT) begin
               shift_q <= shift_nx;
            end
            bit_q <= bit_q + 4'h1;
         end
         if (byte_end) begin
            rx_byte_q <= receiving;
            if (first_q && !master_mode) begin
               if (auto_ack) begin
                  match_q <= addr_hit | gc_hit;
                  ack_drv_q <= addr_hit | gc_hit;
               end else begin
                  match_q <= 1'b1;
                  ack_drv_q <= ackval_q;
               end
            end else begin
               // Only the receiving side drives the acknowledge
               ack_drv_q <= receiving && (first_q || match_q || master_mode) && ackval_q;
            end
         end
         if (scl_fall && (bit_q == `SFAM_ACK_BIT) && !ack_ph_q) begin
            ack_ph_q <= 1'b1;
         end
         // The ACK rise has already stepped the counter, so the phase flag marks the end
         if (ack_end) begin
            ack_ph_q <= 1'b0;
            ack_drv_q <= 1'b0;
            first_q <= 1'b0;
            bit_q <= 4'h0;
         end
      end
   end

   // ************************************************************
   // Flag and register update
   // ************************************************************
   always @(posedge sys_clk or posedge reset) begin
      if (reset) begin
         own_q <= `SFAM_OWN_RESET;
         mask_q <= `SFAM_MASK_RESET;
         si_q <= 1'b0;
         ackrx_q <= 1'b0;
         arb_q <= 1'b0;
         ackreq_q <= 1'b0;
         sta_q <= 1'b0;
         ackval_q <= 1'b0;
      end else begin
         if (sfr_wr && sfr_addr == `SFAM_ADDR_OWN) begin
            own_q <= sfr_wdata;
         end
         if (sfr_wr && sfr_addr == `SFAM_ADDR_MASK) begin
            mask_q <= sfr_wdata;
         end
         if (ctrl_wr) begin
            sta_q <= sfr_wdata[`SFAM_CTRL_STA];
            ackval_q <= sfr_wdata[`SFAM_CTRL_ACKVAL];
         end
         // Set wins over a software clear in the same cycle
         if (si_set) begin
            si_q <= 1'b1;
         end else if (si_clr) begin
            si_q <= 1'b0;
         end
         if (arb_set) begin
            arb_q <= 1'b1;
         end else if (si_clr) begin
            arb_q <= 1'b0;
         end
         if (ack_samp) begin
            ackrx_q <= !sda_s2_q;
         end
         if (byte_end && receiving && !auto_ack) begin
            ackreq_q <= 1'b1;
         end else if (ack_end) begin
            ackreq_q <= 1'b0;
         end
      end
   end

   always @(posedge sys_clk or posedge reset) begin
      if (reset) begin
         sfr_rdata <= 8'h00;
      end else if (sfr_rd) begin
         case (sfr_addr)
            `SFAM_ADDR_CTRL: sfr_rdata <= ctrl_rd;
            `SFAM_ADDR_MASK: sfr_rdata <= mask_q;
            `SFAM_ADDR_OWN: sfr_rdata <= own_q;
            default: sfr_rdata <= 8'h00;
         endcase
      end
   end

   // ************************************************************
   // Two-entry receive buffer
   // ************************************************************
   // Received bytes are pushed at the end of the ACK cycle; a full buffer stretches SCL
   reg [DATA_W-1:0] buf_q [0:1];
   reg [1:0] cnt_q;
   reg rd_q, wr_q;
   wire push = ack_end && rx_byte_q && (match_q || master_mode);
   wire push_ok = push && (cnt_q != 2'd2);
   wire pop = rx_valid && rx_ready;
   assign rx_valid = (cnt_q != 2'd0);
   assign rx_data = buf_q[rd_q];
   always @(posedge sys_clk or posedge reset) begin
      if (reset) begin
         cnt_q <= 2'd0;
         rd_q <= 1'b0;
         wr_q <= 1'b0;
         buf_q[0] <= {DATA_W{1'b0}};
         buf_q[1] <= {DATA_W{1'b0}};
      end else begin
         if (push_ok) begin
            buf_q[wr_q] <= shift_q[DATA_W-1:0];
            wr_q <= ~wr_q;
         end
         if (pop) begin
            rd_q <= ~rd_q;
         end
         if (push_ok && !pop) begin
            cnt_q <= cnt_q + 2'd1;
         end else if (pop && !push_ok) begin
            cnt_q <= cnt_q - 2'd1;
         end
      end
   end

   // ************************************************************
   // Pin drive
   // ************************************************************
   assign addressed = match_q && !master_mode;
   assign sda_out = 1'b0;
   // With auto acknowledge off the answer is read live, so software may reply after the request
   assign sda_oe_n = !(ack_ph_q && (ackreq_q ? ackval_q : ack_drv_q));
   assign scl_out = 1'b0;
   assign scl_oe_n = !(cnt_q == 2'd2);

endmodule

//--- core/sfam_defs.vh
// Register addresses, field positions and reset values of the flag and address match block
`ifndef SFAM_DEFS_VH
`define SFAM_DEFS_VH

// ************************************************************
// Register addresses
// ************************************************************
`define SFAM_ADDR_CTRL 8'hc0
`define SFAM_ADDR_MASK 8'hce
`define SFAM_ADDR_OWN 8'hcf

// ************************************************************
// Control register bit positions
// ************************************************************
`define SFAM_CTRL_SI 0
`define SFAM_CTRL_ACKRX 1
`define SFAM_CTRL_ARBLOST 2
`define SFAM_CTRL_ACKREQ 3
`define SFAM_CTRL_STA 4
`define SFAM_CTRL_ACKVAL 5

// ************************************************************
// Reset values and counts
// ************************************************************
`define SFAM_OWN_RESET 8'h00
`define SFAM_MASK_RESET 8'hfe
`define SFAM_CTRL_RESET 8'h00
`define SFAM_ACK_BIT 4'h8
`define SFAM_LAST_DATA_BIT 4'h7

`endif

//--- testbench/sfam_bus_mdl.sv
// Bus master model driving SCL and SDA open-drain at a 400 ns bit period
`timescale 1ns/1ps
module sfam_bus_mdl (
   output logic scl_low,
   output logic sda_low,
   input wire scl_w,
   input wire sda_w
);
   initial begin
      scl_low = 1'h0;
      sda_low = 1'h0;
   end
   // Works from idle and mid-frame, so it also makes a repeated START
   task automatic start_c;
      sda_low = 1'h0;
      #100 scl_low = 1'h0;
      #100 sda_low = 1'h1;
      #100 scl_low = 1'h1;
      #100;
   endtask
   // Data moves only while SCL is low; a stretched low phase is waited out
   task automatic xfer(input logic [8:0] b, input int n, output logic s);
      for (int i = n - 1; i >= 0; i--) begin
         sda_low = !b[i];
         #100 scl_low = 1'h0;
         wait (scl_w);
         #100 s = sda_w;
         #100 scl_low = 1'h1;
         #100;
      end
   endtask
   task automatic stop_c;
      sda_low = 1'h1;
      #100 scl_low = 1'h0;
      #100 sda_low = 1'h0;
      #200;
   endtask
endmodule

//--- testbench/sfam_core_asserts.sv
// Port-level assertions for the flag and address match core
`timescale 1ns/1ps
module sfam_chk #(
   parameter DATA_W = 8
) (
   input wire sys_clk,
   input wire reset,
   input wire [7:0] sfr_addr,
   input wire sfr_wr,
   input wire sfr_rd,
   input wire [7:0] sfr_wdata,
   input wire [7:0] sfr_rdata,
   input wire scl_in,
   input wire scl_out,
   input wire scl_oe_n,
   input wire sda_out,
   input wire sda_oe_n,
   input wire start_request,
   input wire rx_valid,
   input wire rx_ready,
   input wire [DATA_W-1:0] rx_data
);
   default clocking @(posedge sys_clk);
   endclocking
   default disable iff (reset);
   own_rw_a: assert property (sfr_wr && sfr_addr == 8'hcf ##1 !sfr_wr
      ##1 sfr_rd && sfr_addr == 8'hcf |=> sfr_rdata == $past(sfr_wdata, 3))
      else $error("own address readback wrong");
   sta_bit_a: assert property (sfr_wr && sfr_addr == 8'hc0
      |=> start_request == $past(sfr_wdata[4])) else $error("start request bit wrong");
   ack_start_a: assert property ($fell(sda_oe_n) |-> !scl_in) else $error("ack begun");
   ack_end_a: assert property ($rose(sda_oe_n) |-> !scl_in) else $error("ack ended");
   ack_hold_a: assert property ($fell(sda_oe_n) |=> !sda_oe_n [*5]) else $error("ack short");
   sda_still_a: assert property (scl_in && $past(scl_in) && $past(scl_in, 2)
      |-> $stable(sda_oe_n)) else $error("SDA moved while SCL high");
   head_hold_a: assert property (rx_valid && !rx_ready |=> rx_valid && $stable(rx_data))
      else $error("unpopped byte lost");
   stretch_a: assert property (!scl_oe_n |-> rx_valid) else $error("SCL held while empty");
   pins_low_a: assert property (!sda_out && !scl_out) else $error("pin level high");
endmodule
bind sfam_core sfam_chk #(.DATA_W(DATA_W)) u_chk (.sys_clk, .reset, .sfr_addr, .sfr_wr, .sfr_rd,
   .sfr_wdata, .sfr_rdata, .scl_in, .scl_out, .scl_oe_n, .sda_out, .sda_oe_n, .start_request,
   .rx_valid, .rx_ready, .rx_data);

//--- testbench/test_smbus_flag_update_and_address_match.sv
// Self-checking bench for the flag update and address match core
`timescale 1ns/1ps
module test_smbus_flag_update_and_address_match;
   logic sys_clk, reset, sfr_wr, sfr_rd, rx_ready, master_mode, tx_active, tx_bit_one;
   logic gen_stop_rstart, start_generated, scl_oe_n, sda_oe_n, rx_valid, m_scl, m_sda, addressed;
   logic [7:0] sfr_addr, sfr_wdata, sfr_rdata, rx_data;
   wire scl_w = !m_scl && scl_oe_n;
   wire sda_w = !m_sda && sda_oe_n;
   int err_total, n_compared, cyc;
   // Own register, mask register, address byte, expected acknowledge
   logic [31:0] tbl [7] = '{32'h68ff6801, 32'h68ff6b00, 32'h68ff0000, 32'h69ff0001,
      32'h68fd6b01, 32'he0e7f801, 32'he0e7e200};
   sfam_core #(.DATA_W(8)) u_dut (.sys_clk, .reset, .sfr_addr, .sfr_wr, .sfr_rd, .sfr_wdata,
      .sfr_rdata, .scl_in(scl_w), .sda_in(sda_w), .scl_out(), .scl_oe_n, .sda_out(), .sda_oe_n,
      .master_mode, .tx_active, .tx_bit_one, .gen_stop_rstart, .start_generated,
      .start_request(), .addressed, .rx_valid, .rx_ready, .rx_data);
   sfam_bus_mdl u_mdl (.scl_low(m_scl), .sda_low(m_sda), .scl_w, .sda_w);
   initial begin
      sys_clk = 1'h0;
      forever #25 sys_clk = ~sys_clk;
   end
   always @(posedge sys_clk) begin
      cyc++;
      if (cyc == 20000) begin
         err_total++;
         results();
      end
   end
   task automatic chk(input logic [7:0] got, input logic [7:0] exp);
      n_compared++;
      if (got !== exp) begin
         err_total++;
         $display("unexpected at %0t: got %h want %h", $time, got, exp);
      end
   endtask
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(posedge sys_clk) #1;
      sfr_addr = a;
      sfr_wdata = d;
      sfr_wr = 1'h1;
      @(posedge sys_clk) #1;
      sfr_wr = 1'h0;
   endtask
   task automatic rc(input logic [7:0] a, input logic [7:0] m, input logic [7:0] e);
      @(posedge sys_clk) #1;
      sfr_addr = a;
      sfr_rd = 1'h1;
      @(posedge sys_clk) #1;
      sfr_rd = 1'h0;
      chk(sfr_rdata & m, e);
   endtask
   task automatic pop(input logic [7:0] e);
      // One idle edge keeps rx_ready from being raised in the step it was lowered
      @(posedge sys_clk) #1;
      for (int k = 0; k < 400 && rx_valid !== 1'h1; k++) @(posedge sys_clk) #1;
      chk({7'h0, rx_valid}, 8'h01);
      chk(rx_data, e);
      rx_ready = 1'h1;
      @(posedge sys_clk) #1;
      rx_ready = 1'h0;
   endtask
   task automatic t_regs;
      rc(8'hcf, 8'hff, 8'h00);
      rc(8'hce, 8'hff, 8'hfe);
      rc(8'h55, 8'hff, 8'h00);
      wr(8'hcf, 8'ha5);
      rc(8'hcf, 8'hff, 8'ha5);
      wr(8'hce, 8'h5b);
      rc(8'hce, 8'hff, 8'h5b);
   endtask
   task automatic t_match;
      logic ak;
      foreach (tbl[i]) begin
         wr(8'hcf, tbl[i][31:24]);
         wr(8'hce, tbl[i][23:16]);
         u_mdl.start_c();
         u_mdl.xfer({tbl[i][15:8], 1'h1}, 9, ak);
         chk({7'h0, addressed}, tbl[i][7:0]);
         u_mdl.stop_c();
         chk({7'h0, !ak}, tbl[i][7:0]);
         wr(8'hc0, 8'h00);
      end
   endtask
   task automatic t_flags;
      logic ak;
      wr(8'hce, 8'hfe);
      u_mdl.start_c();
      u_mdl.xfer(9'h0d0, 8, ak);
      rc(8'hc0, 8'h09, 8'h09);
      wr(8'hc0, 8'h21);
      u_mdl.xfer(9'h001, 1, ak);
      chk({7'h0, ak}, 8'h00);
      rc(8'hc0, 8'h09, 8'h01);
      u_mdl.stop_c();
      wr(8'hc0, 8'h00);
   endtask
   task automatic t_arb;
      logic ak;
      {master_mode, tx_active, tx_bit_one} = 3'h7;
      u_mdl.start_c();
      u_mdl.xfer(9'h000, 9, ak);
      rc(8'hc0, 8'h07, 8'h07);
      wr(8'hc0, 8'h00);
      rc(8'hc0, 8'h05, 8'h00);
      gen_stop_rstart = 1'h1;
      repeat (4) @(posedge sys_clk);
      #1 gen_stop_rstart = 1'h0;
      rc(8'hc0, 8'h04, 8'h04);
      wr(8'hc0, 8'h00);
      tx_bit_one = 1'h0;
      u_mdl.xfer(9'h001, 9, ak);
      rc(8'hc0, 8'h07, 8'h01);
      wr(8'hc0, 8'h00);
      wr(8'hc0, 8'h10);
      u_mdl.start_c();
      rc(8'hc0, 8'h04, 8'h00);
      wr(8'hc0, 8'h00);
      u_mdl.start_c();
      rc(8'hc0, 8'h04, 8'h04);
      u_mdl.stop_c();
      wr(8'hc0, 8'h00);
      start_generated = 1'h1;
      @(posedge sys_clk) #1;
      start_generated = 1'h0;
      rc(8'hc0, 8'h01, 8'h01);
      wr(8'hc0, 8'h00);
      {master_mode, tx_active} = 2'h0;
   endtask
   // Sink stalls so the buffer fills and SCL must be held low
   task automatic t_buf;
      logic ak;
      wr(8'hcf, 8'h68);
      wr(8'hce, 8'hff);
      wr(8'hc0, 8'h20);
      rx_ready = 1'h0;
      fork
         begin
            u_mdl.start_c();
            u_mdl.xfer(9'h0d1, 9, ak);
            u_mdl.xfer(9'h14b, 9, ak);
            u_mdl.xfer(9'h079, 9, ak);
            u_mdl.stop_c();
         end
         begin
            repeat (240) @(posedge sys_clk) #1;
            chk({7'h0, scl_oe_n}, 8'h00);
            pop(8'h68);
            pop(8'ha5);
            pop(8'h3c);
         end
      join
      chk({7'h0, ak}, 8'h00);
   endtask
   task automatic results;
      $display("compared %0d, mismatches %0d", n_compared, err_total);
      if (err_total == 0 && n_compared > 0) begin
         $display("TEST PASSED");
      end else begin
         $display("TEST FAILED");
      end
      $finish;
   endtask
   initial begin
      {sfr_wr, sfr_rd, master_mode, tx_active, tx_bit_one, gen_stop_rstart} = 6'h0;
      {reset, rx_ready, start_generated, sfr_addr, sfr_wdata} = 19'h60000;
      repeat (16) @(posedge sys_clk);
      #1 reset = 1'h0;
      t_regs();
      t_match();
      t_flags();
      t_arb();
      t_buf();
      results();
   end
endmodule
